// ### rtl/gpp_pkg.sv
// constants and types for the eight-pin port with pin interrupts
// Contract
// RQ1: mask bit n addresses port pin n
// RQ2: pin read returns real pin level
// RQ3: unselected bits of pin read are zero
// RQ4: software ignores bits above the byte
// RQ5: raw and masked interrupt status views
// RQ6: clear resets only selected pending flags
// RQ7: disable masks selected pins' interrupts
// RQ8: enable unmasks selected pins only
// RQ9: six independent wake-up source enables
// RQ10: handler should clear source early
// RQ11: port request holds while enabled flag pends
// RQ12: peripheral config never selects the function
// RQ13: pin modes: input, output, hardware
// RQ14: detect falling, rising, both, low, high
// RQ15: pin write drives selected outputs only
// RQ16: raw flag sets on event, holds
// RQ17: port interrupt is OR of masked flags
package gpp_pkg;
  localparam int GPP_PINS = 8;         // pins per port
  localparam int GPP_WAKE_SRCS = 6;    // wake-up sources
  localparam int GPP_SYNC_STAGES = 3;  // pin synchroniser depth
  // wake-up source bit positions
  localparam int WAKE_SRC_PORT_FIRST = 0;
  localparam int WAKE_SRC_PORT_SECOND = 1;
  localparam int WAKE_SRC_PORT_THIRD = 2;
  localparam int WAKE_SRC_PORT_FOURTH = 3;
  localparam int WAKE_SRC_USB_UNIT = 4;
  localparam int WAKE_SRC_SLEEP_TIMER = 5;
  // reset values
  localparam logic [7:0] GPP_BYTE_RST = 8'h00;
  localparam logic [5:0] GPP_WAKE_RST = 6'h00;
  // pin control modes
  typedef enum logic [1:0] {
    GPP_MODE_IN = 2'b00,
    GPP_MODE_OUT = 2'b01,
    GPP_MODE_HW_CONTROL = 2'b10
  } gpp_mode_t;
  // interrupt detection kinds
  typedef enum logic [2:0] {
    GPP_DET_FALL = 3'b000,
    GPP_DET_RISE = 3'b001,
    GPP_DET_BOTH = 3'b010,
    GPP_DET_LOW = 3'b011,
    GPP_DET_HIGH = 3'b100
  } gpp_det_t;
endpackage : gpp_pkg

// ### rtl/gpp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module gpp_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [gpp_pkg::GPP_PINS-1:0] pin_i,
  output logic [gpp_pkg::GPP_PINS-1:0] level_o
);
  import gpp_pkg::*;
  logic [GPP_PINS-1:0] s1, s2, s3, lvl;       // stages and filtered level
  logic [GPP_PINS-1:0] next_s1, next_s2, next_s3, next_lvl;
  // next values; change accepted when stages two and three agree
  always_comb begin
    next_s1 = pin_i;
    next_s2 = s1;
    next_s3 = s2;
    next_lvl = lvl;
    for (int i = 0; i < GPP_PINS; i++) begin
      if (s2[i] == s3[i]) begin
        next_lvl[i] = s3[i];
      end
    end
  end
  // registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1 <= GPP_BYTE_RST;
      s2 <= GPP_BYTE_RST;
      s3 <= GPP_BYTE_RST;
      lvl <= GPP_BYTE_RST;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      lvl <= next_lvl;
    end
  end
  assign level_o = lvl;
endmodule : gpp_sync

// ### rtl/gpp_detect.sv
// per-pin interrupt event detector
`timescale 1ns/100ps
module gpp_detect (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [gpp_pkg::GPP_PINS-1:0] level_i,
  input wire logic [3*gpp_pkg::GPP_PINS-1:0] det_i,
  output logic [gpp_pkg::GPP_PINS-1:0] event_o
);
  import gpp_pkg::*;
  logic [GPP_PINS-1:0] prev;  // level one cycle earlier
  logic [GPP_PINS-1:0] next_prev;
  // event per pin by its detection kind
  genvar g;
  generate
    for (g = 0; g < GPP_PINS; g++) begin : g_pin
      always_comb begin
        case (gpp_det_t'(det_i[3*g +: 3]))
          GPP_DET_FALL: event_o[g] = prev[g] & ~level_i[g]; // RQ14
          GPP_DET_RISE: event_o[g] = ~prev[g] & level_i[g];
          GPP_DET_BOTH: event_o[g] = prev[g] ^ level_i[g];
          GPP_DET_LOW: event_o[g] = ~level_i[g];
          GPP_DET_HIGH: event_o[g] = level_i[g];
          default: event_o[g] = 1'b0;
        endcase
      end
    end
  endgenerate
  // next value
  always_comb begin
    next_prev = level_i;
  end
  // register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev <= GPP_BYTE_RST;
    end else begin
      prev <= next_prev;
    end
  end
endmodule : gpp_detect

// ### rtl/gpp_port.sv
// eight-pin port: pin control, read, write, interrupts, wake enables
`timescale 1ns/100ps
module gpp_port (
  input wire logic clk_i,
  input wire logic nrst_i,
  // pin side
  input wire logic [gpp_pkg::GPP_PINS-1:0] pin_i,
  output logic [gpp_pkg::GPP_PINS-1:0] pin_o,
  output logic [gpp_pkg::GPP_PINS-1:0] pin_oe_o,
  // peripheral side for hardware-controlled pins
  input wire logic [gpp_pkg::GPP_PINS-1:0] hw_out_i,
  input wire logic [gpp_pkg::GPP_PINS-1:0] hw_oe_i,
  output logic [gpp_pkg::GPP_PINS-1:0] hw_in_o,
  // mode set
  input wire logic mode_set_i,
  input wire logic [1:0] mode_val_i,
  // detection kind set
  input wire logic det_set_i,
  input wire logic [2:0] det_val_i,
  // pin write
  input wire logic pin_write_i,
  input wire logic [gpp_pkg::GPP_PINS-1:0] pin_write_val_i,
  // pin read
  input wire logic pin_read_i,
  output logic [gpp_pkg::GPP_PINS-1:0] pin_read_data_o,
  // interrupt mask, clear
  input wire logic int_enable_i,
  input wire logic int_disable_i,
  input wire logic int_clear_i,
  // shared selection mask for all pin and interrupt commands; wake commands use wake_cfg_i
  input wire logic [gpp_pkg::GPP_PINS-1:0] pin_select_mask_i,
  // status
  input wire logic status_view_select_i,
  output logic [gpp_pkg::GPP_PINS-1:0] int_status_o,
  output logic [gpp_pkg::GPP_PINS-1:0] int_raw_o,
  output logic [gpp_pkg::GPP_PINS-1:0] int_mask_o,
  output logic port_irq_o,
  // wake-up enables
  input wire logic wake_enable_i,
  input wire logic wake_disable_i,
  input wire logic [gpp_pkg::GPP_WAKE_SRCS-1:0] wake_cfg_i,
  output logic [gpp_pkg::GPP_WAKE_SRCS-1:0] wake_en_o
);
  import gpp_pkg::*;
  logic [GPP_PINS-1:0] level;           // filtered pin levels
  logic [GPP_PINS-1:0] events;          // detection events
  logic [2*GPP_PINS-1:0] mode;          // two bits per pin
  logic [3*GPP_PINS-1:0] det;           // three bits per pin
  logic [GPP_PINS-1:0] out_data;        // software output latch
  logic [GPP_PINS-1:0] raw;             // raw pending flags
  logic [GPP_PINS-1:0] mask;            // interrupt enables
  logic [GPP_PINS-1:0] rd_data;         // pin read result
  logic [GPP_PINS-1:0] status;          // selected status view
  logic irq;                            // port request
  logic [GPP_PINS-1:0] pin_q, oe_q;     // registered pin drive
  logic [GPP_WAKE_SRCS-1:0] wake;       // wake-up enables
  logic [2*GPP_PINS-1:0] next_mode;
  logic [3*GPP_PINS-1:0] next_det;
  logic [GPP_PINS-1:0] next_out_data, next_raw, next_mask, next_rd_data;
  logic [GPP_PINS-1:0] next_status, next_pin_q, next_oe_q;
  logic next_irq;
  logic [GPP_WAKE_SRCS-1:0] next_wake;

  // pin input synchroniser
  gpp_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(pin_i),
    .level_o(level)
  );

  // edge and level detection
  gpp_detect u_detect (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(level),
    .det_i(det),
    .event_o(events)
  );

  // configuration, output latch and pin drive
  always_comb begin
    next_mode = mode;
    next_det = det;
    next_out_data = out_data;
    for (int i = 0; i < GPP_PINS; i++) begin
      // bit i of every mask addresses pin i
      if (pin_select_mask_i[i]) begin // RQ1
        // mode only; function routing lives in the peripheral mux
        if (mode_set_i) begin // RQ12
          next_mode[2*i +: 2] = mode_val_i; // RQ13
        end
        if (det_set_i) begin
          next_det[3*i +: 3] = det_val_i; // RQ14
        end
        // write lands only on software outputs
        if (pin_write_i && gpp_mode_t'(mode[2*i +: 2]) == GPP_MODE_OUT) begin // RQ15
          next_out_data[i] = pin_write_val_i[i];
        end
      end
    end
    // drive per mode
    for (int i = 0; i < GPP_PINS; i++) begin
      case (gpp_mode_t'(next_mode[2*i +: 2]))
        GPP_MODE_OUT: begin // RQ13
          next_pin_q[i] = next_out_data[i];
          next_oe_q[i] = 1'b1;
        end
        GPP_MODE_HW_CONTROL: begin
          next_pin_q[i] = hw_out_i[i];
          next_oe_q[i] = hw_oe_i[i];
        end
        default: begin
          next_pin_q[i] = 1'b0;
          next_oe_q[i] = 1'b0;
        end
      endcase
    end
  end

  // interrupt flags, mask and wake enables
  always_comb begin
    // event set wins over a same-cycle clear
    next_raw = (int_clear_i ? (raw & ~pin_select_mask_i) : raw) | events; // RQ6 RQ16
    next_mask = mask;
    if (int_disable_i) begin
      next_mask = next_mask & ~pin_select_mask_i; // RQ7
    end
    if (int_enable_i) begin
      next_mask = next_mask | pin_select_mask_i; // RQ8
    end
    // views of the flags
    next_status = status_view_select_i ? (next_raw & next_mask) : next_raw; // RQ5
    next_irq = |(next_raw & next_mask); // RQ11 RQ17
    next_wake = wake;
    if (wake_disable_i) begin
      next_wake = next_wake & ~wake_cfg_i; // RQ9
    end
    if (wake_enable_i) begin
      next_wake = next_wake | wake_cfg_i; // RQ9
    end
  end

  // pin read: real level of any selected pin, zero elsewhere
  always_comb begin
    next_rd_data = rd_data;
    if (pin_read_i) begin
      next_rd_data = level & pin_select_mask_i; // RQ2 RQ3
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode <= '0;
      det <= '0;
      out_data <= GPP_BYTE_RST;
      raw <= GPP_BYTE_RST;
      mask <= GPP_BYTE_RST;
      rd_data <= GPP_BYTE_RST;
      status <= GPP_BYTE_RST;
      irq <= 1'b0;
      pin_q <= GPP_BYTE_RST;
      oe_q <= GPP_BYTE_RST;
      wake <= GPP_WAKE_RST;
    end else begin
      mode <= next_mode;
      det <= next_det;
      out_data <= next_out_data;
      raw <= next_raw;
      mask <= next_mask;
      rd_data <= next_rd_data;
      status <= next_status;
      irq <= next_irq;
      pin_q <= next_pin_q;
      oe_q <= next_oe_q;
      wake <= next_wake;
    end
  end

  // outputs straight from flip-flops
  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
  assign hw_in_o = level;
  assign pin_read_data_o = rd_data;
  assign int_status_o = status;
  assign int_raw_o = raw;
  assign int_mask_o = mask;
  assign port_irq_o = irq;
  assign wake_en_o = wake;

  // raw flag set by event, held without clear
  property p_raw_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (events != '0) |=> ((raw & $past(events)) == $past(events));
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw flag missed event"); // RQ16

  // clear leaves unselected flags alone
  property p_clear_sel;
    @(posedge clk_i) disable iff (!nrst_i)
      int_clear_i |=> ((raw & ~$past(pin_select_mask_i)) ==
        (($past(raw) | $past(events)) & ~$past(pin_select_mask_i)));
  endproperty
  a_clear_sel: assert property (p_clear_sel) else $error("clear touched other pins"); // RQ6

  // clear without event drops selected flags
  property p_clear_drop;
    @(posedge clk_i) disable iff (!nrst_i)
      (int_clear_i && events == '0) |=> ((raw & $past(pin_select_mask_i)) == '0);
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("clear did not drop flags"); // RQ6

  // disable masks selected pins
  property p_disable;
    @(posedge clk_i) disable iff (!nrst_i)
      (int_disable_i && !int_enable_i) |=> ((mask & $past(pin_select_mask_i)) == '0);
  endproperty
  a_disable: assert property (p_disable) else $error("disable failed"); // RQ7

  // enable sets selected and keeps others
  property p_enable;
    @(posedge clk_i) disable iff (!nrst_i)
      (int_enable_i && !int_disable_i) |=>
        (mask == ($past(mask) | $past(pin_select_mask_i)));
  endproperty
  a_enable: assert property (p_enable) else $error("enable wrong"); // RQ8

  // request follows masked flags
  property p_irq;
    @(posedge clk_i) disable iff (!nrst_i)
      ##1 (port_irq_o == |(raw & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("port request mismatch"); // RQ11

  // read returns selected levels only
  property p_read;
    @(posedge clk_i) disable iff (!nrst_i)
      pin_read_i |=> (pin_read_data_o == ($past(level) & $past(pin_select_mask_i)));
  endproperty
  a_read: assert property (p_read) else $error("pin read wrong"); // RQ2

  // write to input pin leaves the latch
  property p_write_in;
    @(posedge clk_i) disable iff (!nrst_i)
      pin_write_i && !mode_set_i |=> (out_data & ~oe_q) == ($past(out_data) & ~oe_q);
  endproperty
  a_write_in: assert property (p_write_in) else $error("input pin latch changed"); // RQ15

  // wake enable independence
  property p_wake;
    @(posedge clk_i) disable iff (!nrst_i)
      (wake_enable_i && !wake_disable_i) |=> (wake == ($past(wake) | $past(wake_cfg_i)));
  endproperty
  a_wake: assert property (p_wake) else $error("wake enable wrong"); // RQ9

  // wake disable drops only the chosen sources
  property p_wake_dis;
    @(posedge clk_i) disable iff (!nrst_i)
      (wake_disable_i && !wake_enable_i) |=>
        (wake_en_o == ($past(wake_en_o) & ~$past(wake_cfg_i)));
  endproperty
  a_wake_dis: assert property (p_wake_dis) else $error("wake disable wrong"); // RQ9

  // masked view shows only enabled flags
  property p_view_masked;
    @(posedge clk_i) disable iff (!nrst_i)
      status_view_select_i |=> (int_status_o == (int_raw_o & int_mask_o));
  endproperty
  a_view_masked: assert property (p_view_masked) else $error("masked view wrong"); // RQ5

  // raw view ignores the mask
  property p_view_raw;
    @(posedge clk_i) disable iff (!nrst_i)
      !status_view_select_i |=> (int_status_o == int_raw_o);
  endproperty
  a_view_raw: assert property (p_view_raw) else $error("raw view wrong"); // RQ5

  // request stays up until a clear or a disable
  property p_irq_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (port_irq_o && !int_clear_i && !int_disable_i) |=> port_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("port request dropped"); // RQ11

  // unselected read bits come back zero
  property p_read_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      pin_read_i |=> ((pin_read_data_o & ~$past(pin_select_mask_i)) == '0);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unselected read bit set"); // RQ3

  // read result holds until the next read
  property p_read_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      !pin_read_i |=> $stable(pin_read_data_o);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read result moved"); // RQ2

  // software output mode drives the selected pins
  property p_oe_out;
    @(posedge clk_i) disable iff (!nrst_i)
      (mode_set_i && mode_val_i == GPP_MODE_OUT) |=>
        ((pin_oe_o & $past(pin_select_mask_i)) == $past(pin_select_mask_i));
  endproperty
  a_oe_out: assert property (p_oe_out) else $error("output pin not driven"); // RQ13

  // software input mode releases the selected pins
  property p_oe_in;
    @(posedge clk_i) disable iff (!nrst_i)
      (mode_set_i && mode_val_i == GPP_MODE_IN) |=>
        ((pin_oe_o & $past(pin_select_mask_i)) == '0);
  endproperty
  a_oe_in: assert property (p_oe_in) else $error("input pin still driven"); // RQ13
endmodule : gpp_port

// ### bench/gpp_board.sv
// board model: what the pads show to the port
`timescale 1ns/100ps
module gpp_board (
  input wire logic [7:0] drive_i, // port drive values
  input wire logic [7:0] oe_i, // port drive enables
  input wire logic [7:0] board_i, // board levels where undriven
  output logic [7:0] pad_o // resolved pad levels
);
  // a driven pad shows the port's value, else the board's own level
  always_comb begin
    pad_o = (oe_i & drive_i) | (~oe_i & board_i);
  end
endmodule : gpp_board

// ### bench/tb_top.sv
// self-checking bench for the eight-pin port
`timescale 1ns/100ps
module tb_top;
  import gpp_pkg::*;
  logic clk_i, nrst_i, view;
  logic [8:0] pl; // command pulses
  logic [1:0] mval;
  logic [2:0] dval;
  logic [5:0] wcfg;
  logic [7:0] sel, wval, hw_out, hw_oe, board, pad, pin_o, pin_oe_o, hw_in_o;
  logic [7:0] rd, st, raw, msk;
  logic [5:0] wake;
  logic irq;
  int err_total, comparisons, cyc;
  logic [4:0] ea, eb, ec, ed; // raw pin 4 per detect kind, four steps
  gpp_board i_board (.drive_i(pin_o), .oe_i(pin_oe_o), .board_i(board), .pad_o(pad));
  gpp_port i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .pin_i(pad), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .hw_out_i(hw_out), .hw_oe_i(hw_oe), .hw_in_o(hw_in_o),
    .mode_set_i(pl[0]), .mode_val_i(mval), .det_set_i(pl[1]), .det_val_i(dval),
    .pin_write_i(pl[2]), .pin_write_val_i(wval), .pin_read_i(pl[3]),
    .pin_read_data_o(rd), .int_enable_i(pl[4]), .int_disable_i(pl[5]),
    .int_clear_i(pl[6]), .pin_select_mask_i(sel), .status_view_select_i(view),
    .int_status_o(st), .int_raw_o(raw), .int_mask_o(msk), .port_irq_o(irq),
    .wake_enable_i(pl[7]), .wake_disable_i(pl[8]), .wake_cfg_i(wcfg), .wake_en_o(wake));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // byte compare
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(negedge clk_i);
  endtask : w
  // one-cycle command pulse k with selection m
  task cmd(input int k, input logic [7:0] m);
    @(negedge clk_i);
    sel = m;
    pl[k] = 1'b1;
    @(negedge clk_i);
    pl = '0;
  endtask : cmd
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    {pl, mval, dval, wcfg, sel, wval, hw_out, hw_oe, board, view} = '0;
    nrst_i = 1'b0;
    ea = 5'b01000;
    eb = 5'b11110;
    ec = 5'b10000;
    ed = 5'b11101;
    w(10);
    chk(pin_oe_o | raw | msk, 8'h00, "reset");
    nrst_i = 1'b1;
    // outputs on pins 0 and 3, write all, then pin 0 low
    mval = 2'b01;
    cmd(0, 8'h09);
    wval = 8'hff;
    cmd(2, 8'hff);
    chk(pin_oe_o, 8'h09, "oe");
    chk(pin_o & pin_oe_o, 8'h09, "drive");
    wval = 8'h00;
    cmd(2, 8'h01);
    chk(pin_o & pin_oe_o, 8'h08, "bit0");
    board = 8'ha4;
    w(8);
    cmd(3, 8'h2d);
    chk(rd, 8'h2c, "read");
    chk(hw_in_o, 8'hac, "hwin");
    $display("test pins done");
    // pin 6 under peripheral control, software write ignored
    mval = 2'b10;
    hw_out = 8'h40;
    hw_oe = 8'h40;
    cmd(0, 8'h40);
    cmd(2, 8'h40);
    w(1);
    chk(pin_oe_o, 8'h49, "hwoe");
    chk(pin_o & pin_oe_o, 8'h48, "hwdrv");
    // pin 1 kept no value from the all-pin write made while it was an input
    mval = 2'b01;
    cmd(0, 8'h02);
    chk(pin_oe_o, 8'h4b, "oe1");
    chk(pin_o & pin_oe_o, 8'h48, "wrin");
    mval = 2'b00;
    cmd(0, 8'h02);
    chk(pin_oe_o, 8'h49, "in1");
    $display("test hw done");
    // detect kinds on input pin 4, mask off
    w(8);
    cmd(6, 8'hff);
    chk(raw, 8'h00, "clrall");
    for (int k = 0; k < 5; k++) begin
      dval = k[2:0];
      cmd(1, 8'h10);
      cmd(6, 8'h10);
      w(8);
      chk(raw & 8'h10, {3'h0, ea[k], 4'h0}, "low");
      board[4] = 1'b1;
      w(8);
      chk(raw & 8'h10, {3'h0, eb[k], 4'h0}, "rise");
      cmd(6, 8'h10);
      w(8);
      chk(raw & 8'h10, {3'h0, ec[k], 4'h0}, "high");
      board[4] = 1'b0;
      w(8);
      chk(raw & 8'h10, {3'h0, ed[k], 4'h0}, "fall");
    end
    $display("test detect done");
    // pin 4 flag held from high-level kind
    chk(st, 8'h10, "rawview");
    chk({7'h0, irq}, 8'h00, "irqoff");
    view = 1'b1;
    w(2);
    chk(st, 8'h00, "mskview");
    cmd(4, 8'h30);
    chk(msk, 8'h30, "en");
    chk({7'h0, irq}, 8'h01, "irqon");
    cmd(5, 8'h20);
    chk(msk, 8'h10, "dis");
    cmd(6, 8'h20);
    w(20);
    chk(raw, 8'h10, "clr5");
    chk({7'h0, irq}, 8'h01, "hold");
    chk(st, 8'h10, "st");
    cmd(5, 8'h10);
    chk({7'h0, irq}, 8'h00, "dis4");
    cmd(4, 8'h10);
    cmd(6, 8'h10);
    chk(raw | {7'h0, irq}, 8'h00, "clr4");
    $display("test irq done");
    // wake sources set and cleared independently
    wcfg = 6'h3f;
    cmd(7, 8'h00);
    chk({2'h0, wake}, 8'h3f, "wake");
    wcfg = 6'h05;
    cmd(8, 8'h00);
    chk({2'h0, wake}, 8'h3a, "wdis");
    $display("test wake done");
    finish_test();
  end
endmodule : tb_top
